// File: dv/idl_fieldbus_model.sv
`timescale 1ns/1ps
// ========
// Fieldbus side of the diagnostics link, one subscriber
module idl_fieldbus_model #(
    parameter BIT_CYCLES = 4
) (
    input wire clk_i,
    input wire rx_i,
    output reg tx_o
);
    // Idle high, no session state kept across resets
    initial tx_o = 1'b1;

    // Send one command byte LSB first, collect the reply byte
    task xfer(input [7:0] cmd, output [7:0] rsp, output ok);
        integer i;
        integer k;
        begin
            rsp = 8'h00;
            for (i = 0; i < 9 * BIT_CYCLES; i = i + 1) begin
                @(negedge clk_i);
                tx_o = (i < BIT_CYCLES) ? 1'b0 : cmd[i / BIT_CYCLES - 1];
            end
            @(negedge clk_i);
            tx_o = 1'b1;
            // Bounded wait for the reply start bit
            for (i = 0; i < 8 * BIT_CYCLES && rx_i !== 1'b0; i = i + 1)
                @(negedge clk_i);
            ok = (rx_i === 1'b0);
            if (ok) begin
                repeat (BIT_CYCLES / 2) @(negedge clk_i);
                for (k = 0; k < 8; k = k + 1) begin
                    repeat (BIT_CYCLES) @(negedge clk_i);
                    rsp[k] = rx_i;
                end
            end
            repeat (3 * BIT_CYCLES) @(negedge clk_i);
        end
    endtask
endmodule

// File: dv/idl_interlock_monitor.sv
`timescale 1ns/1ps
`include "idl_consts.vh"
// ========
// Port checker for the interlock outputs
module idl_interlock_monitor #(
    parameter READY_CYCLES = 4
) (
    input wire clk_i,
    input wire srst_i,
    input wire actuator_present_i,
    input wire safety_in_ch1_i,
    input wire safety_in_ch2_i,
    input wire chain_diagnostics_mode_i,
    input wire safety_out_ch1_o,
    input wire safety_out_ch2_o,
    input wire status_diag_out_o,
    input wire [1:0] device_led_o,
    input wire [1:0] input_led_o,
    input wire ready_o,
    input wire diag_busy_o
);
    reg [7:0] since;
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Cycles since reset release, saturating
    always @(posedge clk_i) begin
        if (srst_i)
            since <= 8'h00;
        else if (since != 8'hff)
            since <= since + 8'h01;
    end
    absent_off_a: assert property (
        !actuator_present_i [*3] |=> !safety_out_ch1_o && !safety_out_ch2_o)
        else $error("safety output on without actuator");
    follow_ch1_a: assert property (
        safety_out_ch1_o |-> $past(safety_in_ch1_i, 3) && $past(actuator_present_i, 3))
        else $error("channel 1 output without cause");
    follow_ch2_a: assert property (
        safety_out_ch2_o |-> $past(safety_in_ch2_i, 3) && $past(actuator_present_i, 3))
        else $error("channel 2 output without cause");
    status_presence_a: assert property (
        !chain_diagnostics_mode_i [*5] ##0 ready_o ##0 $past(ready_o)
        |-> status_diag_out_o == $past(actuator_present_i, 3))
        else $error("status output not actuator presence");
    reset_quiet_a: assert property (@(posedge clk_i) disable iff (1'b0)
        srst_i |=> !safety_out_ch1_o && !safety_out_ch2_o && !ready_o)
        else $error("outputs active in reset");
    ready_wait_a: assert property (ready_o |-> since >= READY_CYCLES - 1)
        else $error("ready too early");
    dark_until_ready_a: assert property (!ready_o |-> device_led_o == `IDL_LED_OFF
        && input_led_o == `IDL_LED_OFF && !safety_out_ch1_o && !safety_out_ch2_o)
        else $error("active before ready");
    diag_ignored_a: assert property (
        !chain_diagnostics_mode_i [*5] |-> !diag_busy_o)
        else $error("diag frame outside diag mode");
    // Main scenarios reached
    cover property ($rose(ready_o));
    cover property (device_led_o == `IDL_LED_RED);
    cover property ($rose(diag_busy_o));
endmodule

bind idl_interlock idl_interlock_monitor #(.READY_CYCLES(READY_CYCLES)) mon (
    .clk_i(clk_i), .srst_i(srst_i), .actuator_present_i(actuator_present_i),
    .safety_in_ch1_i(safety_in_ch1_i), .safety_in_ch2_i(safety_in_ch2_i),
    .chain_diagnostics_mode_i(chain_diagnostics_mode_i),
    .safety_out_ch1_o(safety_out_ch1_o), .safety_out_ch2_o(safety_out_ch2_o),
    .status_diag_out_o(status_diag_out_o), .device_led_o(device_led_o),
    .input_led_o(input_led_o), .ready_o(ready_o), .diag_busy_o(diag_busy_o));

// File: dv/tb.sv
`timescale 1ns/1ps
`include "idl_consts.vh"
// ========
// Interlock bench
module tb;
    reg clk_i = 1'b0;
    reg srst_i = 1'b1;
    reg present = 1'b1;
    reg in1 = 1'b0;
    reg in2 = 1'b0;
    reg mode = 1'b0;
    reg [7:0] teach = 8'h2b;
    wire out1, out2, stat, ready, busy, diag;
    wire [1:0] dled, iled;
    integer n_fail = 0;
    integer n_tests = 0;
    // Clock, 8 ns period
    initial forever #4 clk_i = ~clk_i;
    idl_interlock #(.READY_CYCLES(4), .FAST_CYCLES(4), .SLOW_CYCLES(8), .BIT_CYCLES(4))
        DUT (.clk_i(clk_i), .srst_i(srst_i),
        .actuator_present_i(present), .safety_in_ch1_i(in1), .safety_in_ch2_i(in2),
        .chain_diagnostics_mode_i(mode), .diag_in_i(diag), .teach_left_i(teach),
        .safety_out_ch1_o(out1), .safety_out_ch2_o(out2), .status_diag_out_o(stat),
        .device_led_o(dled), .input_led_o(iled), .ready_o(ready), .diag_busy_o(busy));
    idl_fieldbus_model #(.BIT_CYCLES(4)) fb (.clk_i(clk_i), .rx_i(stat), .tx_o(diag));
    // ========
    // Report and compare
    task close_out;
        begin
            $display("tests %0d failures %0d", n_tests, n_fail);
            if (n_fail == 0 && n_tests > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // ========
    // Scenarios
    task do_reset;
        integer i;
        begin
            srst_i = 1'b1;
            repeat (4) @(negedge clk_i);
            srst_i = 1'b0;
            for (i = 0; i < 20 && ready !== 1'b1; i = i + 1)
                @(negedge clk_i);
            chk({7'h00, ready}, 8'h01);
            if (ready !== 1'b1)
                close_out;
            @(negedge clk_i);
            chk({6'h00, dled}, {6'h00, `IDL_LED_GREEN});
        end
    endtask
    task drive(input a, input c1, input c2);
        begin
            @(negedge clk_i);
            present = a;
            in1 = c1;
            in2 = c2;
            repeat (4) @(negedge clk_i);
        end
    endtask
    task row(input [4:0] r);
        begin
            drive(r[4], r[3], r[2]);
            chk({6'h00, out1, out2}, {6'h00, r[1:0]});
            chk({7'h00, stat}, {7'h00, r[4]});
        end
    endtask
    // Both blink colours seen within a window
    task blink;
        integer i;
        reg y;
        reg r;
        begin
            y = 1'b0;
            r = 1'b0;
            for (i = 0; i < 24; i = i + 1) begin
                @(negedge clk_i);
                y = y | (iled === `IDL_LED_YELLOW);
                r = r | (dled === `IDL_LED_RED);
            end
            chk({6'h00, y, r}, 8'h03);
        end
    endtask
    task t_lock;
        begin
            row(5'h1f);
            row(5'h15);
            blink;
            row(5'h1c);
            blink;
            row(5'h14);
            row(5'h1c);
            row(5'h10);
            row(5'h1f);
        end
    endtask
    task ask(input [7:0] cmd, input [7:0] exp);
        reg [7:0] rsp;
        reg ok;
        begin
            fb.xfer(cmd, rsp, ok);
            chk({7'h00, ok}, 8'h01);
            chk(rsp, exp);
            chk({7'h00, busy}, 8'h00);
        end
    endtask
    task t_diag;
        reg [7:0] rsp;
        reg ok;
        begin
            fb.xfer(`IDL_CMD_SERIAL, rsp, ok);
            chk({7'h00, ok}, 8'h00);
            mode = 1'b1;
            repeat (8) @(negedge clk_i);
            ask(`IDL_CMD_STATUS, 8'h07);
            ask(`IDL_CMD_SERIAL, 8'h5a);
            ask(`IDL_CMD_TEACH, teach);
            ask(`IDL_CMD_NAME, 8'h3c);
            ask(8'h00, 8'hff);
            do_reset;
            repeat (8) @(negedge clk_i);
            ask(`IDL_CMD_SERIAL, 8'h5a);
        end
    endtask
    initial begin
        do_reset;
        row(5'h10);
        row(5'h1a);
        row(5'h10);
        row(5'h15);
        row(5'h1f);
        row(5'h0c);
        t_lock;
        t_diag;
        close_out;
    end
endmodule

// File: logic/idl_consts.vh
`ifndef IDL_CONSTS_VH
`define IDL_CONSTS_VH

// ==================================================
// Lockout state machine
`define IDL_ST_NORMAL 2'h0
`define IDL_ST_MISMATCH 2'h1
`define IDL_ST_LOCKOUT 2'h2

// ==================================================
// LED colour codes: off, green, red, yellow
`define IDL_LED_OFF 2'h0
`define IDL_LED_GREEN 2'h1
`define IDL_LED_RED 2'h2
`define IDL_LED_YELLOW 2'h3

// ==================================================
// Blink and ready timing
`define IDL_CLK_MHZ 125
`define IDL_BLINK_FAST_MS 100
`define IDL_BLINK_SLOW_MS 500
`define IDL_READY_US 10

// ==================================================
// Diagnostics frame: 8 data bits, LSB first
`define IDL_DIAG_BITS 8
`define IDL_DIAG_BIT_US 10
`define IDL_CMD_STATUS 8'h01
`define IDL_CMD_SERIAL 8'h02
`define IDL_CMD_TEACH 8'h03
`define IDL_CMD_NAME 8'h04

`endif

// File: logic/idl_diag_port.v
`timescale 1ns/1ps
`include "idl_consts.vh"

// Serial diagnostics responder: receives a command byte, sends one reply byte
module idl_diag_port #(
    parameter BIT_CYCLES = 1250
) (
    input wire clk_i,
    input wire srst_i,
    input wire enable_i,
    input wire rx_i,
    input wire [7:0] status_i,
    input wire [7:0] serial_i,
    input wire [7:0] teach_left_i,
    input wire [7:0] name_i,
    output reg tx_o,
    output reg busy_o
);
    reg rx_prev;
    reg [31:0] cnt;
    reg [3:0] bitn;
    reg [7:0] shreg;
    reg txing;
    reg rxing;
    reg [7:0] next_reply;

    // Reply lookup
    always @* begin
        case (shreg)
            `IDL_CMD_STATUS: next_reply = status_i;
            `IDL_CMD_SERIAL: next_reply = serial_i;
            `IDL_CMD_TEACH: next_reply = teach_left_i;
            `IDL_CMD_NAME: next_reply = name_i;
            default: next_reply = 8'hff;
        endcase
    end

    // Receive start on falling rx, then send reply bits LSB first
    always @(posedge clk_i) begin
        if (srst_i || !enable_i) begin
            rx_prev <= 1'b1;
            cnt <= 32'h0;
            bitn <= 4'h0;
            shreg <= 8'h00;
            txing <= 1'b0;
            rxing <= 1'b0;
            tx_o <= 1'b1;
            busy_o <= 1'b0;
        end else begin
            rx_prev <= rx_i;
            busy_o <= rxing | txing;
            if (!rxing && !txing) begin
                tx_o <= 1'b1;
                if (rx_prev && !rx_i) begin
                    rxing <= 1'b1;
                    cnt <= BIT_CYCLES + BIT_CYCLES / 2 - 1; // Middle of bit 0
                    bitn <= 4'h0;
                end
            end else if (cnt != 32'h0) begin
                cnt <= cnt - 32'h1;
            end else if (rxing) begin
                shreg <= {rx_i, shreg[7:1]};
                cnt <= BIT_CYCLES - 1; // Zero count is one cycle of the bit
                if (bitn == `IDL_DIAG_BITS - 1) begin
                    rxing <= 1'b0;
                    txing <= 1'b1;
                    bitn <= 4'hf;
                end else begin
                    bitn <= bitn + 4'h1;
                end
            end else begin
                cnt <= BIT_CYCLES - 1;
                if (bitn == 4'hf) begin
                    tx_o <= 1'b0; // Start bit
                    shreg <= next_reply;
                    bitn <= 4'h0;
                end else if (bitn == `IDL_DIAG_BITS) begin
                    tx_o <= 1'b1;
                    txing <= 1'b0;
                end else begin
                    tx_o <= shreg[0];
                    shreg <= {1'b0, shreg[7:1]};
                    bitn <= bitn + 4'h1;
                end
            end
        end
    end
endmodule

// File: logic/idl_interlock.v
`timescale 1ns/1ps
`include "idl_consts.vh"

module idl_interlock #(
    parameter READY_CYCLES = `IDL_READY_US * `IDL_CLK_MHZ,
    parameter FAST_CYCLES = `IDL_BLINK_FAST_MS * 1000 * `IDL_CLK_MHZ,
    parameter SLOW_CYCLES = `IDL_BLINK_SLOW_MS * 1000 * `IDL_CLK_MHZ,
    parameter BIT_CYCLES = `IDL_DIAG_BIT_US * `IDL_CLK_MHZ,
    // Arbitrary identity values
    parameter [7:0] SERIAL_NUMBER = 8'h5a,
    parameter [7:0] ACTUATOR_NAME = 8'h3c
) (
    input wire clk_i,
    input wire srst_i,
    input wire actuator_present_i,
    input wire safety_in_ch1_i,
    input wire safety_in_ch2_i,
    input wire chain_diagnostics_mode_i,
    input wire diag_in_i,
    input wire [7:0] teach_left_i,
    output reg safety_out_ch1_o,
    output reg safety_out_ch2_o,
    output reg status_diag_out_o,
    output reg [1:0] device_led_o,
    output reg [1:0] input_led_o,
    output wire ready_o,
    output wire diag_busy_o
);
    // ==================================================
    // Input synchronisers, two stages each
    reg [4:0] sync1;
    reg [4:0] sync2;
    // Safety and presence reset low, diagnostic line idle high
    always @(posedge clk_i) begin
        if (srst_i) begin
            sync1 <= 5'h10;
            sync2 <= 5'h10;
        end else begin
            sync1 <= {diag_in_i, chain_diagnostics_mode_i, actuator_present_i,
                      safety_in_ch2_i, safety_in_ch1_i};
            sync2 <= sync1;
        end
    end
    wire in1 = sync2[0];
    wire in2 = sync2[1];
    wire present = sync2[2];
    wire diag_mode = sync2[3];
    wire diag_rx = sync2[4];

    // ==================================================
    // Ready delay after reset (power-up)
    reg [31:0] ready_cnt;
    reg ready;
    always @(posedge clk_i) begin
        if (srst_i) begin
            ready_cnt <= 32'h0;
            ready <= 1'b0;
        end else if (!ready) begin
            ready_cnt <= ready_cnt + 32'h1;
            ready <= (ready_cnt >= READY_CYCLES - 1);
        end
    end
    assign ready_o = ready;

    // ==================================================
    // Input plausibility state machine
    reg [1:0] state;
    reg [1:0] next_state;
    reg prev1;
    reg prev2;
    reg fell1; // Which channel is currently low
    reg next_fell1;
    // Next state from synchronised levels
    always @* begin
        next_state = state;
        next_fell1 = fell1;
        case (state)
            `IDL_ST_NORMAL: begin
                if (prev1 && prev2 && !in1 && in2) begin
                    next_state = `IDL_ST_MISMATCH;
                    next_fell1 = 1'b1;
                end else if (prev1 && prev2 && in1 && !in2) begin
                    next_state = `IDL_ST_MISMATCH;
                    next_fell1 = 1'b0;
                end
            end
            `IDL_ST_MISMATCH: begin
                if (!in1 && !in2)
                    next_state = `IDL_ST_NORMAL;
                else if (in1 && in2)
                    next_state = `IDL_ST_LOCKOUT;
                else if (fell1 ? in1 : in2)
                    next_fell1 = ~fell1; // Other channel is now the low one
            end
            `IDL_ST_LOCKOUT: begin
                if (!in1 && !in2)
                    next_state = `IDL_ST_NORMAL;
            end
            default: next_state = `IDL_ST_NORMAL;
        endcase
    end
    // State register and previous input levels
    always @(posedge clk_i) begin
        if (srst_i) begin
            state <= `IDL_ST_NORMAL;
            fell1 <= 1'b0;
            prev1 <= 1'b0;
            prev2 <= 1'b0;
        end else begin
            prev1 <= in1;
            prev2 <= in2;
            if (ready) begin
                state <= next_state;
                fell1 <= next_fell1;
            end
        end
    end

    // ==================================================
    // Safety outputs
    wire locked = (state == `IDL_ST_LOCKOUT);
    // Lockout entered this cycle gates outputs at once, no one-cycle pulse
    wire lock_next = (next_state == `IDL_ST_LOCKOUT);
    always @(posedge clk_i) begin
        if (srst_i || !ready) begin
            safety_out_ch1_o <= 1'b0;
            safety_out_ch2_o <= 1'b0;
        end else begin
            safety_out_ch1_o <= present & in1 & ~lock_next;
            safety_out_ch2_o <= present & in2 & ~lock_next;
        end
    end

    // ==================================================
    // Diagnostics responder, restarts on every reset
    wire diag_tx;
    wire [7:0] diag_status = {4'h0, locked, safety_out_ch2_o, safety_out_ch1_o, present};
    idl_diag_port #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_diag (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .enable_i(ready & diag_mode),
        .rx_i(diag_rx),
        .status_i(diag_status),
        .serial_i(SERIAL_NUMBER),
        .teach_left_i(teach_left_i),
        .name_i(ACTUATOR_NAME),
        .tx_o(diag_tx),
        .busy_o(diag_busy_o)
    );

    // Status output: presence or diag data
    always @(posedge clk_i) begin
        if (srst_i || !ready)
            status_diag_out_o <= 1'b0;
        else if (diag_mode)
            status_diag_out_o <= diag_tx;
        else
            status_diag_out_o <= present;
    end

    // ==================================================
    // Blink timebases and LEDs
    reg [31:0] fast_cnt;
    reg [31:0] slow_cnt;
    reg fast_ph;
    reg slow_ph;
    // Free-running blink phase generators
    always @(posedge clk_i) begin
        if (srst_i) begin
            fast_cnt <= 32'h0;
            slow_cnt <= 32'h0;
            fast_ph <= 1'b0;
            slow_ph <= 1'b0;
        end else begin
            fast_cnt <= (fast_cnt >= FAST_CYCLES - 1) ? 32'h0 : fast_cnt + 32'h1;
            slow_cnt <= (slow_cnt >= SLOW_CYCLES - 1) ? 32'h0 : slow_cnt + 32'h1;
            if (fast_cnt >= FAST_CYCLES - 1)
                fast_ph <= ~fast_ph;
            if (slow_cnt >= SLOW_CYCLES - 1)
                slow_ph <= ~slow_ph;
        end
    end

    // LED patterns per plausibility state
    always @(posedge clk_i) begin
        if (srst_i || !ready) begin
            device_led_o <= `IDL_LED_OFF;
            input_led_o <= `IDL_LED_OFF;
        end else begin
            case (state)
                `IDL_ST_MISMATCH: begin
                    device_led_o <= slow_ph ? `IDL_LED_RED : `IDL_LED_OFF;
                    input_led_o <= fast_ph ? `IDL_LED_YELLOW : `IDL_LED_OFF;
                end
                `IDL_ST_LOCKOUT: begin
                    device_led_o <= slow_ph ? `IDL_LED_RED : `IDL_LED_OFF;
                    input_led_o <= slow_ph ? `IDL_LED_YELLOW : `IDL_LED_OFF;
                end
                default: begin
                    device_led_o <= `IDL_LED_GREEN;
                    input_led_o <= (in1 & in2) ? `IDL_LED_YELLOW : `IDL_LED_OFF;
                end
            endcase
        end
    end
endmodule
